//--- pkg/sfcs_defines.vh
`ifndef SFCS_DEFINES_VH
`define SFCS_DEFINES_VH
// ----------------------------------------
// timing figures, in their own units
// ----------------------------------------
`define SFCS_CLK_PERIOD_NS 10
`define SFCS_INIT_TIME_US 1000
`define SFCS_PROG_MIN_NS 500
// derived cycle counts (least times round up)
`define SFCS_INIT_CYCLES ((`SFCS_INIT_TIME_US * 1000 + `SFCS_CLK_PERIOD_NS - 1) / `SFCS_CLK_PERIOD_NS)
`define SFCS_PROG_CYCLES ((`SFCS_PROG_MIN_NS + `SFCS_CLK_PERIOD_NS - 1) / `SFCS_CLK_PERIOD_NS)
// ----------------------------------------
// link command and image size
// ----------------------------------------
`define SFCS_READ_CMD 8'h03
`define SFCS_CMD_BITS 32
`define SFCS_IMAGE_BITS_MIN 581344
`define SFCS_IMAGE_BITS_MAX 5969696
// link clock divider slow half period in system cycles, and lowest rate option code
`define SFCS_SLOW_HALF 16'h0032
`define SFCS_RATE_OPT_LOW 8'h01
// image bit position of the rate option byte, and length in bits of the checksum word
`define SFCS_RATE_POS 32
`define SFCS_CRC_BITS 32
`endif

//--- src/sfcs_config_startup.v
`timescale 1ns/100ps
`include "sfcs_defines.vh"
module sfcs_config_startup #(
	parameter INIT_CYCLES = `SFCS_INIT_CYCLES, // shorten in simulation
	parameter IMAGE_BITS = `SFCS_IMAGE_BITS_MIN // per family member
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire core_supply_good,
	input wire auxiliary_supply_good,
	input wire flash_bank_io_supply_good,
	input wire program_request_n,
	input wire init_n_in,
	output reg init_n_out,
	output reg init_n_oe,
	input wire done_in,
	output reg done_out,
	output reg done_oe,
	output reg flash_select_n,
	output reg config_link_clock,
	output reg mosi,
	input wire din,
	output reg [7:0] clock_rate_option,
	output reg image_bit,
	output reg image_bit_valid
);
// ----------------------------------------
// state codes
// ----------------------------------------
localparam ST_POR = 3'h0; // waiting for supplies
localparam ST_CLEAR = 3'h1; // clearing config memory
localparam ST_WAIT = 3'h2; // init released, waiting for pins high
localparam ST_CMD = 3'h3; // shifting command and address
localparam ST_READ = 3'h4; // reading image bits
localparam ST_DONE = 3'h5; // configured
localparam ST_FAIL = 3'h6; // checksum error, parked
// ----------------------------------------
// input synchronisers
// ----------------------------------------
reg [2:0] sup_s1_reg; // first stage, read only by second
reg [2:0] sup_s2_reg;
reg prog_s1_reg;
reg prog_s2_reg;
reg init_s1_reg;
reg init_s2_reg;
reg din_s1_reg;
reg din_s2_reg;
always @(posedge clk_sys) begin
	if (sys_rst) begin
		sup_s1_reg <= 3'h0;
		sup_s2_reg <= 3'h0;
		prog_s1_reg <= 1'b0;
		prog_s2_reg <= 1'b0;
		init_s1_reg <= 1'b0;
		init_s2_reg <= 1'b0;
		din_s1_reg <= 1'b0;
		din_s2_reg <= 1'b0;
	end else begin
		sup_s1_reg <= {core_supply_good, auxiliary_supply_good, flash_bank_io_supply_good};
		sup_s2_reg <= sup_s1_reg;
		prog_s1_reg <= program_request_n;
		prog_s2_reg <= prog_s1_reg;
		init_s1_reg <= init_n_in;
		init_s2_reg <= init_s1_reg;
		din_s1_reg <= din;
		din_s2_reg <= din_s1_reg;
	end
end
wire supplies_ok = &sup_s2_reg;
// ----------------------------------------
// program pulse width filter
// ----------------------------------------
// a glitch shorter than the minimum must not restart a running load
reg [7:0] prog_cnt_reg;
reg prog_armed_reg; // long enough low seen
always @(posedge clk_sys) begin
	if (sys_rst) begin
		prog_cnt_reg <= 8'h00;
		prog_armed_reg <= 1'b0;
	end else if (!prog_s2_reg) begin
		if (prog_cnt_reg < `SFCS_PROG_CYCLES) begin
			prog_cnt_reg <= prog_cnt_reg + 8'h01;
		end else begin
			prog_armed_reg <= 1'b1;
		end
	end else begin
		prog_cnt_reg <= 8'h00;
		prog_armed_reg <= 1'b0;
	end
end
// restart fires on the release after a long enough low
wire restart = prog_armed_reg && prog_s2_reg;
// ----------------------------------------
// link clock divider
// ----------------------------------------
reg [15:0] half_reg; // active half period
reg [15:0] div_cnt_reg;
reg link_run_reg; // link clock toggling
reg rise_en; // one-cycle enable at link rising edge
reg fall_en; // one-cycle enable at link falling edge
always @* begin
	rise_en = 1'b0;
	fall_en = 1'b0;
	if (link_run_reg && div_cnt_reg == 16'h0000) begin
		rise_en = !config_link_clock;
		fall_en = config_link_clock;
	end
end
// option code n gives half period slow/n, at least 1: a higher code is never a slower link
function [15:0] rate_half;
	input [7:0] opt;
	begin
		if (opt <= `SFCS_RATE_OPT_LOW) begin
			rate_half = `SFCS_SLOW_HALF;
		end else begin
			rate_half = `SFCS_SLOW_HALF / {8'h00, opt};
			if (rate_half == 16'h0000) begin
				rate_half = 16'h0001;
			end
		end
	end
endfunction
always @(posedge clk_sys) begin
	if (sys_rst) begin
		div_cnt_reg <= 16'h0000;
		config_link_clock <= 1'b0;
	end else if (!link_run_reg) begin
		// preloaded so the first link rise comes a full slow half period after select
		div_cnt_reg <= half_reg - 16'h0001;
		config_link_clock <= 1'b0;
	end else if (div_cnt_reg == 16'h0000) begin
		div_cnt_reg <= half_reg - 16'h0001;
		config_link_clock <= !config_link_clock;
	end else begin
		div_cnt_reg <= div_cnt_reg - 16'h0001;
	end
end
// ----------------------------------------
// main sequencer
// ----------------------------------------
reg [2:0] state_reg;
reg [19:0] init_cnt_reg;
reg [22:0] bit_cnt_reg;
reg [31:0] shift_reg; // command out, also checksum window in
reg [31:0] crc_reg; // running image checksum
wire [31:0] read_word = {`SFCS_READ_CMD, 24'h000000}; // address 0
// simple rotate-xor checksum; the last word of the image must match it
function [31:0] crc_step;
	input [31:0] c;
	input b;
	begin
		crc_step = {c[30:0], c[31] ^ b};
	end
endfunction
always @(posedge clk_sys) begin
	if (sys_rst || restart || !supplies_ok) begin
		// back to power-on state; restart also clears done and init
		state_reg <= ST_POR;
		init_cnt_reg <= 20'h00000;
		bit_cnt_reg <= 23'h000000;
		shift_reg <= 32'h00000000;
		crc_reg <= 32'h00000000;
		half_reg <= `SFCS_SLOW_HALF;
		link_run_reg <= 1'b0;
		flash_select_n <= 1'b1;
		mosi <= 1'b0;
		init_n_out <= 1'b0;
		init_n_oe <= 1'b0;
		done_out <= 1'b0;
		done_oe <= 1'b1;
		clock_rate_option <= `SFCS_RATE_OPT_LOW;
		image_bit <= 1'b0;
		image_bit_valid <= 1'b0;
	end else begin
		image_bit_valid <= 1'b0;
		case (state_reg)
		ST_POR: begin
			// held low by program pin postpones the start
			if (prog_s2_reg) begin
				state_reg <= ST_CLEAR;
				init_cnt_reg <= 20'h00000;
				init_n_oe <= 1'b1; // init low while clearing
			end
		end
		ST_CLEAR: begin
			flash_select_n <= 1'b1;
			if (init_cnt_reg >= INIT_CYCLES - 1) begin
				init_n_oe <= 1'b0;
				state_reg <= ST_WAIT;
			end else begin
				init_cnt_reg <= init_cnt_reg + 20'h00001;
			end
		end
		ST_WAIT: begin
			// external hold on init or program delays the read for a slow flash
			if (init_s2_reg && prog_s2_reg) begin
				flash_select_n <= 1'b0;
				link_run_reg <= 1'b1;
				shift_reg <= read_word;
				mosi <= read_word[31];
				bit_cnt_reg <= 23'h000000;
				state_reg <= ST_CMD;
			end
		end
		ST_CMD: begin
			if (fall_en) begin
				if (bit_cnt_reg == `SFCS_CMD_BITS - 1) begin
					bit_cnt_reg <= 23'h000000;
					state_reg <= ST_READ; // no path back: sent once
				end else begin
					shift_reg <= {shift_reg[30:0], 1'b0};
					mosi <= shift_reg[30];
					bit_cnt_reg <= bit_cnt_reg + 23'h000001;
				end
			end
		end
		ST_READ: begin
			if (rise_en) begin
				image_bit <= din_s2_reg;
				image_bit_valid <= 1'b1;
				shift_reg <= {shift_reg[30:0], din_s2_reg};
				if (bit_cnt_reg < IMAGE_BITS - `SFCS_CRC_BITS) begin
					crc_reg <= crc_step(crc_reg, din_s2_reg);
				end
				// rate option byte follows the header word
				if (bit_cnt_reg == `SFCS_RATE_POS + 7) begin
					clock_rate_option <= {shift_reg[6:0], din_s2_reg};
					half_reg <= rate_half({shift_reg[6:0], din_s2_reg});
				end
				if (bit_cnt_reg == IMAGE_BITS - 1) begin
					link_run_reg <= 1'b0;
					flash_select_n <= 1'b1;
					if ({shift_reg[30:0], din_s2_reg} == crc_reg) begin
						done_oe <= 1'b0;
						done_out <= 1'b1;
						state_reg <= ST_DONE;
					end else begin
						init_n_oe <= 1'b1;
						state_reg <= ST_FAIL;
					end
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 23'h000001;
				end
			end
		end
		ST_DONE: begin
			done_oe <= 1'b0; // released, pulled high outside
		end
		ST_FAIL: begin
			init_n_oe <= 1'b1; // held until program restart
		end
		default: begin
			state_reg <= ST_POR;
		end
		endcase
	end
end
endmodule // sfcs_config_startup

//--- dv/sfcs_flash_model.sv
`timescale 1ns/100ps
// serial flash stand-in: takes a 32-bit command, then streams the image
module sfcs_flash_model #(
	parameter N = 80
) (
	input wire sel_n,
	input wire sck,
	input wire si,
	output logic so,
	input wire [N-1:0] image,
	output logic [31:0] cmd,
	output int n_sel
);
	int cnt; // link rises seen in this frame
	initial begin
		so = 1'b0;
		n_sel = 0;
	end
	// a new frame starts the shift count again
	always @(negedge sel_n) begin
		cnt = 0;
		n_sel++;
	end
	// no pull on the line: once released it shows the opposite level
	always @(posedge sel_n) so <= ~so;
	// command bits are taken on the rising link clock
	always @(posedge sck) if (!sel_n) begin
		if (cnt < 32) cmd = {cmd[30:0], si};
		cnt++;
	end
	// ready at select: data moves on the falling clock, first bit at the top
	always @(negedge sck) if (!sel_n && cnt >= 32 && cnt < 32 + N) so <= image[N-1-(cnt-32)];
endmodule // sfcs_flash_model

//--- dv/sfcs_config_startup_chk.sv
`timescale 1ns/100ps
// ----
// pin checks on the loader
// ----
module sfcs_config_startup_chk #(
	parameter INIT_CYCLES = 20,
	parameter IMAGE_BITS = 80
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire core_supply_good,
	input wire auxiliary_supply_good,
	input wire flash_bank_io_supply_good,
	input wire init_n_oe,
	input wire done_out,
	input wire done_oe,
	input wire flash_select_n,
	input wire config_link_clock,
	input wire mosi,
	input wire [7:0] clock_rate_option,
	input wire image_bit_valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_sel_clear; !flash_select_n |-> !init_n_oe; endproperty
	a_sel_clear: assert property (p_sel_clear) else $error("select while clearing");
	property p_sel_pwr; $fell(flash_select_n) |-> core_supply_good && auxiliary_supply_good
		&& flash_bank_io_supply_good; endproperty
	a_sel_pwr: assert property (p_sel_pwr) else $error("select without supplies");
	property p_slow; $fell(flash_select_n) |-> (!config_link_clock) [*8]; endproperty
	a_slow: assert property (p_slow) else $error("link clock too fast");
	property p_rate; $fell(flash_select_n) |-> clock_rate_option == 8'h01; endproperty
	a_rate: assert property (p_rate) else $error("not lowest rate");
	// mosi may move only while the link clock is low
	property p_mosi; !flash_select_n && config_link_clock |-> $stable(mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved");
	property p_valid; image_bit_valid |-> !$past(flash_select_n); endproperty
	a_valid: assert property (p_valid) else $error("bit outside frame");
	property p_busy; !flash_select_n |-> !done_out && done_oe; endproperty
	a_busy: assert property (p_busy) else $error("done during load");
	property p_done; done_out |-> !done_oe; endproperty
	a_done: assert property (p_done) else $error("done still pulled");
	// received bits since the last clearing; a frame must close on the last image bit
	logic [22:0] bit_seen_reg;
	always @(posedge clk_sys) begin
		if (sys_rst || init_n_oe) begin
			bit_seen_reg <= 23'h000000;
		end else if (image_bit_valid) begin
			bit_seen_reg <= bit_seen_reg + 23'h000001;
		end
	end
	property p_nbits; $rose(flash_select_n) && image_bit_valid |-> bit_seen_reg == IMAGE_BITS - 1; endproperty
	a_nbits: assert property (p_nbits) else $error("frame length wrong");
	c_sel: cover property ($fell(flash_select_n));
	c_done: cover property ($rose(done_out));
	c_bit: cover property (image_bit_valid);
endmodule // sfcs_config_startup_chk
bind sfcs_config_startup sfcs_config_startup_chk #(.INIT_CYCLES(INIT_CYCLES), .IMAGE_BITS(IMAGE_BITS)) u_chk (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.core_supply_good(core_supply_good),
	.auxiliary_supply_good(auxiliary_supply_good),
	.flash_bank_io_supply_good(flash_bank_io_supply_good),
	.init_n_oe(init_n_oe),
	.done_out(done_out),
	.done_oe(done_oe),
	.flash_select_n(flash_select_n),
	.config_link_clock(config_link_clock),
	.mosi(mosi),
	.clock_rate_option(clock_rate_option),
	.image_bit_valid(image_bit_valid)
);

//--- dv/sfcs_config_startup_test.sv
`timescale 1ns/100ps
module sfcs_config_startup_test;
	localparam N = 80;
	localparam logic [47:0] HEAD = {32'hA5C3_0F96, 8'h05, 8'h3C};
	logic clk_sys, sys_rst, sup_c, sup_a, sup_b, program_request_n, hold_n;
	wire init_n_out, init_n_oe, done_out, done_oe, flash_select_n, config_link_clock, mosi, din, image_bit;
	wire image_bit_valid;
	wire [7:0] clock_rate_option;
	wire init_w = (init_n_oe ? init_n_out : 1'b1) && hold_n; // open drain with pull-up
	wire done_w = done_oe ? done_out : 1'b1; // open drain with pull-up
	logic [N-1:0] image;
	logic [31:0] cmd;
	int n_sel, n_errors = 0, total_checks = 0, cyc = 0, nbits;
	sfcs_config_startup #(.INIT_CYCLES(20), .IMAGE_BITS(N)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.core_supply_good(sup_c), .auxiliary_supply_good(sup_a), .flash_bank_io_supply_good(sup_b),
		.program_request_n(program_request_n), .init_n_in(init_w), .init_n_out(init_n_out), .init_n_oe(init_n_oe),
		.done_in(done_w), .done_out(done_out), .done_oe(done_oe), .flash_select_n(flash_select_n),
		.config_link_clock(config_link_clock), .mosi(mosi), .din(din), .clock_rate_option(clock_rate_option),
		.image_bit(image_bit), .image_bit_valid(image_bit_valid));
	sfcs_flash_model #(.N(N)) u_flash (.sel_n(flash_select_n), .sck(config_link_clock), .si(mosi),
		.so(din), .image(image), .cmd(cmd), .n_sel(n_sel));
	// ----
	// helpers
	// ----
	initial begin
		clk_sys = 0;
		forever #5 clk_sys = ~clk_sys;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	function automatic logic [31:0] crc(input logic [47:0] d);
		logic [31:0] c;
		c = 0;
		for (int i = 47; i >= 0; i--) c = {c[30:0], c[31] ^ d[i]};
		return c;
	endfunction
	// every received bit against the stored image
	always @(negedge clk_sys) if (image_bit_valid === 1'b1) begin
		check(image_bit, image[N-1-nbits], "image bit");
		nbits++;
	end
	// hang guard well above two loads
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			close_out;
		end
	end
	task wait_sel(input logic lvl, input int lim);
		int k;
		k = 0;
		while (flash_select_n !== lvl && k < lim) begin
			@(negedge clk_sys);
			k++;
		end
		check(flash_select_n, lvl, "select");
	endtask
	task run_load(input logic good);
		nbits = 0;
		wait_sel(0, 200);
		check(clock_rate_option, 8'h01, "start rate");
		wait_sel(1, 20000);
		repeat (3) @(negedge clk_sys);
		check(cmd, 32'h0300_0000, "command");
		check(nbits, N, "bit count");
		check(done_out, good, "done");
		check(done_w, good, "done pin");
		check(init_n_oe, !good, "init");
		check(init_w, good, "init pin");
		check(clock_rate_option, 8'h05, "rate");
	endtask
	// ----
	// scenarios
	// ----
	task t_power;
		sup_c = 1;
		sup_a = 1;
		repeat (40) @(negedge clk_sys);
		check(init_n_oe, 0, "early clear");
		sup_b = 1;
		repeat (5) @(negedge clk_sys);
		check(init_n_oe, 1, "clearing");
		repeat (60) @(negedge clk_sys);
		check(flash_select_n, 1, "held off");
		hold_n = 1;
		run_load(1);
		$display("t_power done");
	endtask
	task t_restart;
		image = {HEAD, ~crc(HEAD)};
		program_request_n = 0;
		repeat (60) @(negedge clk_sys);
		program_request_n = 1;
		check(n_sel, 1, "one read");
		run_load(0);
		check(n_sel, 2, "reads");
		$display("t_restart done");
	endtask
	task t_short;
		program_request_n = 0;
		repeat (30) @(negedge clk_sys);
		program_request_n = 1;
		repeat (300) @(negedge clk_sys);
		check(n_sel, 2, "short pulse");
		check(init_n_oe, 1, "fail kept");
		$display("t_short done");
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		sys_rst = 1;
		sup_c = 0;
		sup_a = 0;
		sup_b = 0;
		program_request_n = 1;
		hold_n = 0;
		image = {HEAD, crc(HEAD)};
		repeat (8) @(negedge clk_sys);
		sys_rst = 0;
		t_power;
		t_restart;
		t_short;
		close_out;
	end
endmodule // sfcs_config_startup_test
